// ==== rtl/ecp_top.sv ====
// Functional notes
// - writing one to clear bits 15..6 clears that latched event; zero does nothing
// - clear register bits 5..0 always read zero
// - clear bits drop by themselves once flag and test bit are clear
// - clearing a test-forced event also clears its test bit and flag
// - events other than sag and swell are evaluated once per computation cycle
// - trailing mean-square voltage from the engine feeds sag and swell detection
// - each data-ready compares that voltage to sag and swell limits, sets flags
// - sag and swell use no hold qualification
// - masked sag or swell drives the notification pin high
// - sag and swell stay latched until host clears them
// - four multipurpose pins with input, notify, address and thermistor modes
// - notification pins follow the event masks of their class
// - pins reset to logic input and mirror live state to status
// - strap low at reset makes pins zero and one address inputs
// - strap high means single-device mode, address ignored, pins free
// - pin two as thermistor input makes thermistor register hold converter reading
// - pin two as output makes thermistor register read zero
// - code 101 is standard output, 100 critical output; pin three bits 11..9
// - code 010 is logic input and the reset value of every field
// - pin two field bits 8..6, code 011 is thermistor input
// - pin one bits 5..3, pin zero bits 2..0, code 011 is address input
// - configuration bits 15..12 read zero
`timescale 1ns/1ps
`default_nettype none
`include "ecp_consts.svh"

module ecp_top #(
    parameter int VMS_W = 16,
    parameter int THERM_W = 16,
    parameter int PIN_N = 4
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [15:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic [15:0] reg_wr_data,
    input wire logic reg_rd_en,
    output logic [15:0] reg_rd_data,
    output logic reg_rd_valid,
    input wire logic comp_cycle_stb,
    input wire logic [`ECP_EVT_N-3:0] limit_trip,
    input wire logic data_ready,
    input wire logic [VMS_W-1:0] vms_trailing,
    input wire logic [`ECP_EVT_N-1:0] test_force,
    output logic [`ECP_EVT_N-1:0] test_clear_req,
    input wire logic [`ECP_EVT_N-1:0] std_mask,
    input wire logic [`ECP_EVT_N-1:0] crit_mask,
    output logic [15:0] event_flags,
    output logic std_notify,
    output logic crit_notify,
    input wire logic [PIN_N-1:0] pin_in,
    output logic [PIN_N-1:0] pin_out,
    output logic [PIN_N-1:0] pin_oe,
    input wire logic mode_strap,
    output logic [PIN_N-1:0] pin_state,
    output logic multi_dev,
    output logic [1:0] dev_addr,
    input wire logic [THERM_W-1:0] therm_adc,
    input wire logic therm_valid,
    output logic [THERM_W-1:0] therm_volt
);
    localparam int EN = `ECP_EVT_N;

    // register storage
    logic [EN-1:0] flag_reg;
    logic [EN-1:0] flag_next;
    logic [EN-1:0] clr_pend_reg;
    logic [EN-1:0] clr_pend_next;
    logic [`ECP_CFG_BITS-1:0] cfg_reg;
    logic [VMS_W-1:0] sag_lim_reg;
    logic [VMS_W-1:0] swell_lim_reg;
    logic [THERM_W-1:0] therm_reg;
    logic [15:0] rd_data_reg;
    logic rd_valid_reg;

    // pin and strap synchronisers; stage one is read only by stage two
    logic [PIN_N-1:0] pin_meta_reg;
    logic [PIN_N-1:0] pin_sync_reg;
    logic strap_meta_reg;
    logic strap_sync_reg;
    logic [1:0] strap_cnt_reg;
    logic strap_done_reg;
    logic multi_reg;

    // address decode
    wire hit_cfg = reg_addr == `ECP_OFS_PIN_CFG;
    wire hit_clr = reg_addr == `ECP_OFS_EVT_CLEAR;
    wire hit_sag = reg_addr == `ECP_OFS_SAG_LIMIT;
    wire hit_swell = reg_addr == `ECP_OFS_SWELL_LIMIT;
    wire hit_therm = reg_addr == `ECP_OFS_THERM_VOLT;
    wire wr_clr = reg_wr_en & hit_clr;

    // one-cycle clear strobe per event, only where a one was written
    wire [EN-1:0] clr_wr = wr_clr ? reg_wr_data[15:`ECP_EVT_LO] : '0;

    // sag/swell detector link
    ecp_sag_if #(.VMS_W(VMS_W)) sif ();
    assign sif.data_ready = data_ready;
    assign sif.vms = vms_trailing;
    assign sif.sag_limit = sag_lim_reg;
    assign sif.swell_limit = swell_lim_reg;

    ecp_sag_det u_sag (
        .clk(clk),
        .rst(rst),
        .sif(sif)
    );

    // event sources: limit alarms only on the computation-cycle strobe
    wire [EN-1:0] real_set = {limit_trip & {(EN-2){comp_cycle_stb}},
                              sif.sag_hit, sif.swell_hit};
    // a forced event being cleared no longer re-sets its flag
    wire [EN-1:0] test_set = test_force & ~clr_pend_reg & ~clr_wr;
    wire [EN-1:0] any_set = real_set | test_set;

    // set wins over clear, so an event in the clear cycle survives
    always_comb begin
        flag_next = (flag_reg & ~clr_wr) | any_set;
        clr_pend_next = (clr_pend_reg | clr_wr)
                      & ~(~flag_reg & ~test_force & ~clr_wr);
    end

    // pending clear requests the matching test bit to drop as well
    assign test_clear_req = clr_pend_reg & test_force;

    always_ff @(posedge clk) begin
        if (rst) begin
            flag_reg <= '0;
            clr_pend_reg <= '0;
        end else begin
            flag_reg <= flag_next;
            clr_pend_reg <= clr_pend_next;
        end
    end

    assign event_flags = {flag_reg, 6'h00};

    // notification classes follow their masks; active high
    wire std_act = |(flag_reg & std_mask);
    wire crit_act = |(flag_reg & crit_mask);
    assign std_notify = std_act;
    assign crit_notify = crit_act;

    // configuration and limit registers
    always_ff @(posedge clk) begin
        if (rst) begin
            cfg_reg <= `ECP_CFG_RESET;
            sag_lim_reg <= `ECP_SAG_LIMIT_RESET;
            swell_lim_reg <= `ECP_SWELL_LIMIT_RESET;
        end else if (reg_wr_en) begin
            if (hit_cfg) begin
                cfg_reg <= reg_wr_data[`ECP_CFG_BITS-1:0];
            end
            if (hit_sag) begin
                sag_lim_reg <= reg_wr_data[VMS_W-1:0];
            end
            if (hit_swell) begin
                swell_lim_reg <= reg_wr_data[VMS_W-1:0];
            end
        end
    end

    // pin and strap synchronisers
    always_ff @(posedge clk) begin
        pin_meta_reg <= pin_in;
        pin_sync_reg <= pin_meta_reg;
        strap_meta_reg <= mode_strap;
        strap_sync_reg <= strap_meta_reg;
    end

    // strap is caught once, after the synchroniser has settled past reset
    always_ff @(posedge clk) begin
        if (rst) begin
            strap_cnt_reg <= 2'h0;
            strap_done_reg <= 1'b0;
            multi_reg <= 1'b0;
        end else if (!strap_done_reg) begin
            if (strap_cnt_reg == `ECP_STRAP_SETTLE) begin
                strap_done_reg <= 1'b1;
                multi_reg <= ~strap_sync_reg;
            end else begin
                strap_cnt_reg <= strap_cnt_reg + 2'h1;
            end
        end
    end

    assign multi_dev = multi_reg;

    // per-pin mode decode and drive
    ecp_pkg::ecp_pin_mode_t pin_mode [PIN_N];
    genvar gi;
    generate
        for (gi = 0; gi < PIN_N; gi++) begin : g_pin
            wire [2:0] code = cfg_reg[gi*`ECP_CFG_W +: `ECP_CFG_W];
            wire is_addr_pin = (gi == `ECP_PIN_ADDR_LO) || (gi == `ECP_PIN_ADDR_HI);
            wire is_therm_pin = gi == `ECP_PIN_THERM;
            // multi-device mode takes the address pins over regardless of code
            assign pin_mode[gi] =
                (is_addr_pin && multi_reg) ? ecp_pkg::ECP_MODE_ADDR :
                (code == `ECP_CODE_STD) ? ecp_pkg::ECP_MODE_STD :
                (code == `ECP_CODE_CRIT) ? ecp_pkg::ECP_MODE_CRIT :
                (code == `ECP_CODE_SPECIAL && is_therm_pin) ? ecp_pkg::ECP_MODE_THERM :
                (code == `ECP_CODE_SPECIAL && is_addr_pin) ? ecp_pkg::ECP_MODE_ADDR :
                ecp_pkg::ECP_MODE_INPUT;
            assign pin_oe[gi] = (pin_mode[gi] == ecp_pkg::ECP_MODE_STD)
                              | (pin_mode[gi] == ecp_pkg::ECP_MODE_CRIT);
            assign pin_out[gi] = ((pin_mode[gi] == ecp_pkg::ECP_MODE_STD) & std_act)
                               | ((pin_mode[gi] == ecp_pkg::ECP_MODE_CRIT) & crit_act);
        end
    endgenerate

    // live pin state for the status register, driven pins read their own level
    assign pin_state = pin_sync_reg;

    // address bits only count in multi-device mode; ignored otherwise
    assign dev_addr = multi_reg ? pin_sync_reg[1:0] : 2'h0;

    // thermistor reading is held only while pin two is a sensor input
    wire therm_mode = pin_mode[`ECP_PIN_THERM] == ecp_pkg::ECP_MODE_THERM;
    always_ff @(posedge clk) begin
        if (rst) begin
            therm_reg <= '0;
        end else if (!therm_mode) begin
            therm_reg <= '0;
        end else if (therm_valid) begin
            therm_reg <= therm_adc;
        end
    end

    assign therm_volt = therm_reg;

    // read mux; unmapped addresses and unused bits read zero
    wire [15:0] rd_clr = {clr_pend_reg, 6'h00};
    wire [15:0] rd_cfg = {4'h0, cfg_reg};
    wire [15:0] rd_mux = hit_clr ? rd_clr :
                         hit_cfg ? rd_cfg :
                         hit_sag ? 16'(sag_lim_reg) :
                         hit_swell ? 16'(swell_lim_reg) :
                         hit_therm ? 16'(therm_reg) : 16'h0000;

    always_ff @(posedge clk) begin
        if (rst) begin
            rd_data_reg <= 16'h0000;
            rd_valid_reg <= 1'b0;
        end else begin
            rd_valid_reg <= reg_rd_en;
            if (reg_rd_en) begin
                rd_data_reg <= rd_mux;
            end
        end
    end

    assign reg_rd_data = rd_data_reg;
    assign reg_rd_valid = rd_valid_reg;

    // checks
    sequence s_clr_write(int i);
        wr_clr && reg_wr_data[`ECP_EVT_LO + i] && !any_set[i];
    endsequence

    a_clear_drops_flag: assert property (@(posedge clk) disable iff (rst)
        s_clr_write(3) |=> !flag_reg[3])
        else $error("event flag survived a clear write");

    a_zero_keeps_flag: assert property (@(posedge clk) disable iff (rst)
        wr_clr && !reg_wr_data[`ECP_EVT_LO + 2] && flag_reg[2] |=> flag_reg[2])
        else $error("writing zero cleared an event");

    a_low_clear_zero: assert property (@(posedge clk) disable iff (rst)
        reg_rd_valid && $past(hit_clr) |-> reg_rd_data[5:0] == 6'h00)
        else $error("clear register low bits not zero");

    a_pend_self_clears: assert property (@(posedge clk) disable iff (rst)
        clr_pend_reg[2] && !flag_reg[2] && !test_force[2] && !clr_wr[2] |=> !clr_pend_reg[2])
        else $error("clear bit stayed latched");

    a_limit_waits_cycle: assert property (@(posedge clk) disable iff (rst)
        !flag_reg[2] && !comp_cycle_stb && !test_force[2] |=> !flag_reg[2])
        else $error("limit event set outside a computation cycle");

    a_sag_latches: assert property (@(posedge clk) disable iff (rst)
        flag_reg[`ECP_EVT_SAG] && !clr_wr[`ECP_EVT_SAG] |=> flag_reg[`ECP_EVT_SAG])
        else $error("sag event dropped without a clear");

    a_sag_to_pin: assert property (@(posedge clk) disable iff (rst)
        sif.sag_hit && std_mask[`ECP_EVT_SAG] && pin_mode[3] == ecp_pkg::ECP_MODE_STD
        |=> pin_out[3] && pin_oe[3])
        else $error("masked sag did not raise the standard pin");

    a_therm_zero_out: assert property (@(posedge clk) disable iff (rst)
        pin_oe[`ECP_PIN_THERM] |=> therm_volt == '0)
        else $error("thermistor register nonzero while pin two drives");

    a_reserved_input: assert property (@(posedge clk) disable iff (rst)
        cfg_reg[11:9] == 3'h7 |-> !pin_oe[3])
        else $error("reserved code drove a pin");

    a_single_no_addr: assert property (@(posedge clk) disable iff (rst)
        strap_done_reg && !multi_reg |-> dev_addr == 2'h0)
        else $error("address bits used in single-device mode");
endmodule

`default_nettype wire

// ==== rtl/ecp_consts.svh ====
`ifndef ECP_CONSTS_SVH
`define ECP_CONSTS_SVH

// register offsets on the internal register port
`define ECP_OFS_THERM_VOLT 16'h001A
`define ECP_OFS_PIN_CFG 16'h0046
`define ECP_OFS_SAG_LIMIT 16'h0086
`define ECP_OFS_SWELL_LIMIT 16'h0088
`define ECP_OFS_EVT_CLEAR 16'h0092

// event clear field: implemented bits 15..6, low six read as zero
`define ECP_EVT_LO 6
`define ECP_EVT_N 10
`define ECP_EVT_SWELL 0
`define ECP_EVT_SAG 1

// pin configuration field layout and codes
`define ECP_CFG_W 3
`define ECP_CFG_BITS 12
`define ECP_CFG_RESET 12'h492
`define ECP_CODE_STD 3'h5
`define ECP_CODE_CRIT 3'h4
`define ECP_CODE_SPECIAL 3'h3
`define ECP_CODE_INPUT 3'h2
`define ECP_PIN_ADDR_LO 0
`define ECP_PIN_ADDR_HI 1
`define ECP_PIN_THERM 2

// limit reset values and strap settle count (cycles after reset release)
`define ECP_SAG_LIMIT_RESET 16'h0000
`define ECP_SWELL_LIMIT_RESET 16'hFFFF
`define ECP_STRAP_SETTLE 2'h3

`endif

// ==== rtl/ecp_pkg.sv ====
package ecp_pkg;

    // effective behaviour of one multipurpose pin, one-hot
    typedef enum logic [4:0] {
        ECP_MODE_INPUT = 5'b00001,
        ECP_MODE_STD = 5'b00010,
        ECP_MODE_CRIT = 5'b00100,
        ECP_MODE_ADDR = 5'b01000,
        ECP_MODE_THERM = 5'b10000
    } ecp_pin_mode_t;

endpackage

// ==== rtl/ecp_sag_if.sv ====
`timescale 1ns/1ps
`default_nettype none

// carries the trailing mean-square voltage and limits to the sag detector
interface ecp_sag_if #(
    parameter int VMS_W = 16
);
    logic data_ready;
    logic [VMS_W-1:0] vms;
    logic [VMS_W-1:0] sag_limit;
    logic [VMS_W-1:0] swell_limit;
    logic sag_hit;
    logic swell_hit;

    modport ctrl (output data_ready, output vms, output sag_limit, output swell_limit,
                  input sag_hit, input swell_hit);
    modport det (input data_ready, input vms, input sag_limit, input swell_limit,
                 output sag_hit, output swell_hit);
endinterface

`default_nettype wire

// ==== rtl/ecp_sag_det.sv ====
`timescale 1ns/1ps
`default_nettype none

module ecp_sag_det (
    input wire logic clk,
    input wire logic rst,
    ecp_sag_if.det sif
);
    // threshold compares, evaluated only on a data-ready strobe
    wire sag_cmp = sif.vms < sif.sag_limit;
    wire swell_cmp = sif.vms > sif.swell_limit;

    logic sag_reg;
    logic swell_reg;

    // no hold qualification: a single sample beyond the limit is enough
    always_ff @(posedge clk) begin
        if (rst) begin
            sag_reg <= 1'b0;
            swell_reg <= 1'b0;
        end else begin
            sag_reg <= sif.data_ready & sag_cmp;
            swell_reg <= sif.data_ready & swell_cmp;
        end
    end

    assign sif.sag_hit = sag_reg;
    assign sif.swell_hit = swell_reg;

    sequence s_sag_sample;
        sif.data_ready && (sif.vms < sif.sag_limit);
    endsequence

    a_sag_one_sample: assert property (@(posedge clk) disable iff (rst)
        s_sag_sample |=> sif.sag_hit)
        else $error("sag not flagged one cycle after low sample");

    a_swell_only_ready: assert property (@(posedge clk) disable iff (rst)
        sif.swell_hit |-> $past(sif.data_ready) && $past(sif.vms > sif.swell_limit))
        else $error("swell hit without a data-ready sample above limit");
endmodule

`default_nettype wire

// ==== tb/ecp_test_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// stands in for the event test register that sits outside the block
module ecp_test_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic [9:0] set_req,
    input wire logic [9:0] test_clear_req,
    output logic [9:0] test_force
);
    logic [9:0] force_reg;
    logic [9:0] force_next;

    // a clear request beats a new set, so the device's auto-clear always lands
    assign force_next = (force_reg | set_req) & ~test_clear_req;
    always_ff @(posedge clk) begin
        if (rst) begin
            force_reg <= 10'h000;
        end else begin
            force_reg <= force_next;
        end
    end
    assign test_force = force_reg;
endmodule

`default_nettype wire

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ecp_consts.svh"
// case inequality so that an unknown never passes for a match
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin miscompares++; $display("ERROR t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module testbench;
    int miscompares = 0;
    int cmp_count = 0;
    logic clk, rst, reg_wr_en, reg_rd_en, reg_rd_valid, comp_cycle_stb, data_ready;
    logic std_notify, crit_notify, mode_strap, multi_dev, therm_valid;
    logic [15:0] reg_addr, reg_wr_data, reg_rd_data, vms_trailing, therm_adc, therm_volt;
    logic [15:0] event_flags;
    logic [7:0] limit_trip;
    logic [9:0] test_force, test_clear_req, std_mask, crit_mask, set_req;
    logic [3:0] pin_in, pin_out, pin_oe, pin_state;
    logic [1:0] dev_addr;

    ecp_top u_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
        .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data),
        .reg_rd_valid(reg_rd_valid), .comp_cycle_stb(comp_cycle_stb), .limit_trip(limit_trip),
        .data_ready(data_ready), .vms_trailing(vms_trailing), .test_force(test_force),
        .test_clear_req(test_clear_req), .std_mask(std_mask), .crit_mask(crit_mask),
        .event_flags(event_flags), .std_notify(std_notify), .crit_notify(crit_notify),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .mode_strap(mode_strap),
        .pin_state(pin_state), .multi_dev(multi_dev), .dev_addr(dev_addr),
        .therm_adc(therm_adc), .therm_valid(therm_valid), .therm_volt(therm_volt));

    ecp_test_model u_model (.clk(clk), .rst(rst), .set_req(set_req),
        .test_clear_req(test_clear_req), .test_force(test_force));

    // 20 MHz clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic conclude;
        $display("comparisons=%0d miscompares=%0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // step past the edge so registered outputs have landed
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic do_reset(input logic strap);
        @(posedge clk);
        rst <= 1'b1;
        mode_strap <= strap;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        settle(6);
    endtask

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wr_data <= d;
        reg_wr_en <= 1'b1;
        @(posedge clk);
        reg_wr_en <= 1'b0;
    endtask

    // read answer stands one cycle after the read edge
    task automatic rchk(input logic [15:0] a, input logic [15:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd_en <= 1'b1;
        @(posedge clk);
        reg_rd_en <= 1'b0;
        #1;
        `CHK(reg_rd_valid, 1'b1)
        `CHK(reg_rd_data, e)
    endtask

    // one sample, then park the voltage between the two limits
    task automatic dr_pulse(input logic [15:0] v);
        @(posedge clk);
        vms_trailing <= v;
        data_ready <= 1'b1;
        @(posedge clk);
        data_ready <= 1'b0;
        vms_trailing <= 16'h1800;
        settle(2);
    endtask

    task automatic t_reset_vals;
        rchk(`ECP_OFS_PIN_CFG, 16'h0492);
        rchk(`ECP_OFS_EVT_CLEAR, 16'h0000);
        `CHK(pin_oe, 4'h0)
        `CHK(pin_state, 4'hA)
        `CHK(multi_dev, 1'b0)
    endtask

    task automatic t_cfg_notify;
        wr(`ECP_OFS_PIN_CFG, 16'hFB12);
        rchk(`ECP_OFS_PIN_CFG, 16'h0B12);
        `CHK(pin_oe, 4'hC)
        @(posedge clk);
        std_mask <= 10'h004;
        crit_mask <= 10'h004;
        limit_trip <= 8'h01;
        settle(3);
        `CHK(event_flags, 16'h0000)
        @(posedge clk);
        comp_cycle_stb <= 1'b1;
        @(posedge clk);
        comp_cycle_stb <= 1'b0;
        limit_trip <= 8'h00;
        settle(2);
        `CHK(event_flags, 16'h0100)
        `CHK({pin_out[3:2], std_notify, crit_notify}, 4'hF)
        wr(`ECP_OFS_EVT_CLEAR, 16'hFEFF);
        settle(2);
        `CHK(event_flags, 16'h0100)
        wr(`ECP_OFS_EVT_CLEAR, 16'h0100);
        settle(2);
        `CHK(event_flags, 16'h0000)
        `CHK(pin_out[3:2], 2'b00)
        wr(`ECP_OFS_PIN_CFG, 16'h0E93);
        settle(2);
        `CHK(pin_oe, 4'h0)
        `CHK(dev_addr, 2'b00)
    endtask

    task automatic t_sag;
        wr(`ECP_OFS_SAG_LIMIT, 16'h1000);
        wr(`ECP_OFS_SWELL_LIMIT, 16'h2000);
        wr(`ECP_OFS_PIN_CFG, 16'h0B12);
        std_mask <= 10'h002;
        crit_mask <= 10'h001;
        dr_pulse(16'h1000);
        `CHK(event_flags, 16'h0000)
        dr_pulse(16'h0800);
        `CHK(event_flags, 16'h0080)
        `CHK(pin_out[3:2], 2'b10)
        dr_pulse(16'h3000);
        `CHK(event_flags, 16'h00C0)
        `CHK(pin_out[3:2], 2'b11)
        settle(4);
        `CHK(event_flags, 16'h00C0)
        wr(`ECP_OFS_EVT_CLEAR, 16'h00C0);
        settle(2);
        `CHK(event_flags, 16'h0000)
    endtask

    task automatic t_test_force;
        @(posedge clk);
        set_req <= 10'h004;
        @(posedge clk);
        set_req <= 10'h000;
        settle(2);
        `CHK(event_flags, 16'h0100)
        wr(`ECP_OFS_EVT_CLEAR, 16'h0100);
        settle(4);
        `CHK(test_force, 10'h000)
        `CHK(event_flags, 16'h0000)
        rchk(`ECP_OFS_EVT_CLEAR, 16'h0000);
    endtask

    task automatic t_therm(input logic [15:0] cfg, input logic [15:0] e);
        wr(`ECP_OFS_PIN_CFG, cfg);
        @(posedge clk);
        therm_valid <= 1'b1;
        @(posedge clk);
        therm_valid <= 1'b0;
        settle(2);
        rchk(`ECP_OFS_THERM_VOLT, e);
        `CHK(therm_volt, e)
    endtask

    task automatic t_strap;
        do_reset(1'b0);
        `CHK(multi_dev, 1'b1)
        `CHK(dev_addr, 2'b10)
        wr(`ECP_OFS_PIN_CFG, 16'h04AD);
        settle(2);
        `CHK(pin_oe[1:0], 2'b00)
    endtask

    initial begin
        rst = 1'b1;
        mode_strap = 1'b1;
        {reg_wr_en, reg_rd_en, comp_cycle_stb, data_ready, therm_valid} = 5'h00;
        {reg_addr, reg_wr_data, vms_trailing} = 48'h0000_0000_0000;
        therm_adc = 16'h1234;
        limit_trip = 8'h00;
        {std_mask, crit_mask, set_req} = 30'h0000_0000;
        pin_in = 4'hA;
        do_reset(1'b1);
        t_reset_vals();
        t_cfg_notify();
        t_sag();
        t_test_force();
        t_therm(16'h0B12, 16'h0000);
        t_therm(16'h04D2, 16'h1234);
        t_therm(16'h0512, 16'h0000);
        t_strap();
        conclude();
    end

    // a hang counts as a mismatch and goes to the report
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        conclude();
    end
endmodule

`default_nettype wire
